/* hw/irq_flags_pkg.sv */
// Purpose: shared constants and types for the peripheral request flag block
// Assumes: classic wishbone, 32-bit data, word-aligned registers
// Notes:   offsets are byte addresses
package irq_flags_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam int         ADDR_W            = 5;
    localparam logic [4:0] FLAGS0_OFFSET     = 5'h00;
    localparam logic [4:0] FLAGS1_OFFSET     = 5'h04;
    localparam logic [4:0] STATUS_OFFSET     = 5'h08;
    localparam logic [4:0] RISE_MASK_OFFSET  = 5'h0c;
    localparam logic [4:0] FALL_MASK_OFFSET  = 5'h10;
    localparam logic [7:0] FLAGS_RESET       = 8'h00;
    localparam logic [7:0] FLAGS0_IMPL_MASK  = 8'h31;
    localparam logic [7:0] FLAGS0_WRITE_MASK = 8'h21;
    localparam logic [7:0] FLAGS1_WRITE_MASK = 8'hcf;

    // ----------------------------------------
    // bit positions
    // ----------------------------------------
    localparam int TIMER0_OVF_BIT   = 5;
    localparam int PIN_SUMMARY_BIT  = 4;
    localparam int EXT_PIN_BIT      = 0;
    localparam int TIMER1_GATE_BIT  = 7;
    localparam int CONV_DONE_BIT    = 6;
    localparam int RX_PENDING_BIT   = 5;
    localparam int TX_EMPTY_BIT     = 4;
    localparam int SYNC_DONE_BIT    = 3;
    localparam int BUS_COLL_BIT     = 2;
    localparam int TIMER2_MATCH_BIT = 1;
    localparam int TIMER1_OVF_BIT   = 0;

    // ----------------------------------------
    // pin-change ports
    // ----------------------------------------
    localparam int PORT_COUNT = 3;
    localparam int PORT_PINS  = 8;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK  = 2'b01
    } bus_state_t;

    typedef struct packed {
        logic timer0_overflow;
        logic ext_pin;
        logic timer1_gate_closed;
        logic conversion_done;
        logic rx_not_empty;
        logic tx_empty;
        logic sync_serial_done;
        logic bus_collision;
        logic timer2_match;
        logic timer1_overflow;
    } irq_events_t;

endpackage

/* hw/pin_change_detect.sv */
// Purpose: per-pin edge detection with separate rising and falling masks
// Assumes: pins are asynchronous to clk_i
// Notes:   per_port_change_flags cleared by software writes of zero
`timescale 1ns/1ps
`default_nettype none
module pin_change_detect (
    input  wire logic                                                     clk_i,
    input  wire logic                                                     rst_i,
    input  wire logic [irq_flags_pkg::PORT_COUNT*irq_flags_pkg::PORT_PINS-1:0] pins_i,
    input  wire logic [irq_flags_pkg::PORT_COUNT*irq_flags_pkg::PORT_PINS-1:0] rising_edge_mask_i,
    input  wire logic [irq_flags_pkg::PORT_COUNT*irq_flags_pkg::PORT_PINS-1:0] falling_edge_mask_i,
    input  wire logic [irq_flags_pkg::PORT_COUNT*irq_flags_pkg::PORT_PINS-1:0] clear_i,
    output logic      [irq_flags_pkg::PORT_COUNT*irq_flags_pkg::PORT_PINS-1:0] per_port_change_flags_o
);
    localparam int N = irq_flags_pkg::PORT_COUNT * irq_flags_pkg::PORT_PINS;

    // ----------------------------------------
    // three-stage sync and edge flags
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_pin
            logic [2:0] sync_reg;
            logic       level_reg;
            logic       agree;
            logic       rise;
            logic       fall;
            // chain free-runs so it holds the pin level by the end of reset
            always_ff @(posedge clk_i) begin
                sync_reg <= {sync_reg[1:0], pins_i[g]};
            end
            assign agree = sync_reg[1] == sync_reg[2];
            // settled level, loaded in reset: a pin held high gives no false edge
            always_ff @(posedge clk_i) begin
                if (rst_i || agree) begin
                    level_reg <= sync_reg[2];
                end
            end
            assign rise = agree & sync_reg[2] & ~level_reg;
            assign fall = agree & ~sync_reg[2] & level_reg;
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    per_port_change_flags_o[g] <= 1'b0;
                end else if ((rise & rising_edge_mask_i[g]) | (fall & falling_edge_mask_i[g])) begin
                    per_port_change_flags_o[g] <= 1'b1;
                end else if (clear_i[g]) begin
                    per_port_change_flags_o[g] <= 1'b0;
                end
            end

            property p_edge_only;
                @(posedge clk_i) disable iff (rst_i)
                    !per_port_change_flags_o[g] ##1 per_port_change_flags_o[g]
                    |-> $past((rise & rising_edge_mask_i[g]) | (fall & falling_edge_mask_i[g]));
            endproperty
            a_edge_only: assert property (p_edge_only) else $error("pin flag set without enabled edge");
        end
    endgenerate
endmodule
`default_nettype wire

/* hw/peripheral_irq_flags.sv */
// Purpose: two peripheral interrupt request flag registers on wishbone
// Assumes: event inputs are one-cycle pulses on clk_i; status inputs are levels
// Notes:   per-port flags at 0x08, rising mask at 0x0c, falling mask at 0x10
// Function
// - first register bits 7,6 and 3..1 read zero and ignore writes.
// - timer 0 overflow sets bit 5; cleared by writing zero.
// - bit 4 is read-only OR of all per-port pin-change flags.
// - pin-change flag sets only on an enabled, individually masked edge.
// - external pin event sets bit 0; cleared by software.
// - event flags set regardless of any enable bits.
// - timer 1 gate closing sets second register bit 7; writable clear.
// - conversion complete sets bit 6; writable clear.
// - bit 5 read-only, one while receive buffer holds data.
// - bit 4 read-only, one while transmit buffer is empty.
// - sync serial completion sets bit 3 until software clears it.
// - bus collision sets bit 2 until software clears it.
// - timer 2 period match sets bit 1 until software clears it.
// - timer 1 overflow sets bit 0 until software clears it.
// - all implemented flags except second register bits 5 and 4 reset to zero on every reset.
`timescale 1ns/1ps
`default_nettype none
module peripheral_irq_flags (
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        cyc_i,
    input  wire logic                        stb_i,
    input  wire logic                        we_i,
    input  wire logic [3:0]                  sel_i,
    input  wire logic [31:0]                 adr_i,
    input  wire logic [31:0]                 dat_i,
    output logic      [31:0]                 dat_o,
    output logic                             ack_o,
    input  wire irq_flags_pkg::irq_events_t  events_i,
    input  wire logic [23:0]                 pins_i,
    output logic      [7:0]                  periph_request_flags_0_o,
    output logic      [7:0]                  periph_request_flags_1_o
);
    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    logic        req;
    logic        wr_stb;
    logic        hit0;
    logic        hit1;
    logic        hit_st;
    logic        hit_rise;
    logic        hit_fall;
    logic [4:0]  word_adr;
    logic [7:0]  clr0;
    logic [7:0]  clr1;
    logic [7:0]  flags0_reg;
    logic [7:0]  flags1_reg;
    logic [23:0] rise_mask_reg;
    logic [23:0] fall_mask_reg;
    logic [23:0] port_flags;
    logic [23:0] port_clr;
    logic        summary;
    logic [7:0]  set1;
    logic [7:0]  rd0;
    logic [7:0]  rd1;
    irq_flags_pkg::bus_state_t state_reg;

    assign req      = cyc_i & stb_i & (state_reg == irq_flags_pkg::BUS_IDLE);
    assign word_adr = adr_i[irq_flags_pkg::ADDR_W-1:0];
    assign hit0     = word_adr == irq_flags_pkg::FLAGS0_OFFSET;
    assign hit1     = word_adr == irq_flags_pkg::FLAGS1_OFFSET;
    assign hit_st   = word_adr == irq_flags_pkg::STATUS_OFFSET;
    assign hit_rise = word_adr == irq_flags_pkg::RISE_MASK_OFFSET;
    assign hit_fall = word_adr == irq_flags_pkg::FALL_MASK_OFFSET;
    assign wr_stb   = req & we_i;

    // clear mask: writing zero to a writable bit clears it
    assign clr0 = (wr_stb & hit0 & sel_i[0]) ? (~dat_i[7:0] & irq_flags_pkg::FLAGS0_WRITE_MASK) : 8'h00;
    assign clr1 = (wr_stb & hit1 & sel_i[0]) ? (~dat_i[7:0] & irq_flags_pkg::FLAGS1_WRITE_MASK) : 8'h00;

    // ----------------------------------------
    // single-cycle ack state machine
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= irq_flags_pkg::BUS_IDLE;
        end else begin
            case (state_reg)
                irq_flags_pkg::BUS_IDLE: if (req) state_reg <= irq_flags_pkg::BUS_ACK;
                irq_flags_pkg::BUS_ACK:  state_reg <= irq_flags_pkg::BUS_IDLE;
                default:                 state_reg <= irq_flags_pkg::BUS_IDLE;
            endcase
        end
    end

    assign ack_o = (state_reg == irq_flags_pkg::BUS_ACK);

    // ----------------------------------------
    // pin-change masks and per-port flags
    // ----------------------------------------
    // status word: [23:0] per-port flags (write 0 to clear); mask words above
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rise_mask_reg <= 24'h000000;
            fall_mask_reg <= 24'h000000;
        end else if (wr_stb && hit_rise) begin
            rise_mask_reg <= dat_i[23:0];
        end else if (wr_stb && hit_fall) begin
            fall_mask_reg <= dat_i[23:0];
        end
    end

    assign port_clr = (wr_stb & hit_st) ? ~dat_i[23:0] : 24'h000000;

    pin_change_detect u_pcd (
        .clk_i                   (clk_i),
        .rst_i                   (rst_i),
        .pins_i                  (pins_i),
        .rising_edge_mask_i      (rise_mask_reg),
        .falling_edge_mask_i     (fall_mask_reg),
        .clear_i                 (port_clr),
        .per_port_change_flags_o (port_flags)
    );

    assign summary = |port_flags;

    // ----------------------------------------
    // sticky flags
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags0_reg <= irq_flags_pkg::FLAGS_RESET;
        end else begin
            flags0_reg[irq_flags_pkg::TIMER0_OVF_BIT] <= events_i.timer0_overflow |
                (flags0_reg[irq_flags_pkg::TIMER0_OVF_BIT] & ~clr0[irq_flags_pkg::TIMER0_OVF_BIT]);
            flags0_reg[irq_flags_pkg::EXT_PIN_BIT] <= events_i.ext_pin |
                (flags0_reg[irq_flags_pkg::EXT_PIN_BIT] & ~clr0[irq_flags_pkg::EXT_PIN_BIT]);
        end
    end

    always_comb begin
        set1 = 8'h00;
        set1[irq_flags_pkg::TIMER1_GATE_BIT]  = events_i.timer1_gate_closed;
        set1[irq_flags_pkg::CONV_DONE_BIT]    = events_i.conversion_done;
        set1[irq_flags_pkg::SYNC_DONE_BIT]    = events_i.sync_serial_done;
        set1[irq_flags_pkg::BUS_COLL_BIT]     = events_i.bus_collision;
        set1[irq_flags_pkg::TIMER2_MATCH_BIT] = events_i.timer2_match;
        set1[irq_flags_pkg::TIMER1_OVF_BIT]   = events_i.timer1_overflow;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags1_reg <= irq_flags_pkg::FLAGS_RESET;
        end else begin
            flags1_reg <= (set1 | (flags1_reg & ~clr1)) & irq_flags_pkg::FLAGS1_WRITE_MASK;
        end
    end

    // ----------------------------------------
    // read view
    // ----------------------------------------
    always_comb begin
        rd0 = flags0_reg & irq_flags_pkg::FLAGS0_IMPL_MASK;
        rd0[irq_flags_pkg::PIN_SUMMARY_BIT] = summary;
        rd1 = flags1_reg;
        rd1[irq_flags_pkg::RX_PENDING_BIT] = events_i.rx_not_empty;
        rd1[irq_flags_pkg::TX_EMPTY_BIT]   = events_i.tx_empty;
    end

    assign periph_request_flags_0_o = rd0;
    assign periph_request_flags_1_o = rd1;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h00000000;
        end else if (req) begin
            if (hit0) begin
                dat_o <= {24'h000000, rd0};
            end else if (hit1) begin
                dat_o <= {24'h000000, rd1};
            end else if (hit_st) begin
                dat_o <= {8'h00, port_flags};
            end else if (hit_rise) begin
                dat_o <= {8'h00, rise_mask_reg};
            end else if (hit_fall) begin
                dat_o <= {8'h00, fall_mask_reg};
            end else begin
                dat_o <= 32'h00000000;
            end
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_unimpl_zero;
        @(posedge clk_i) disable iff (rst_i) (rd0 & ~irq_flags_pkg::FLAGS0_IMPL_MASK) == 8'h00;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bits nonzero");

    property p_t0_set;
        @(posedge clk_i) disable iff (rst_i) events_i.timer0_overflow |=> rd0[irq_flags_pkg::TIMER0_OVF_BIT];
    endproperty
    a_t0_set: assert property (p_t0_set) else $error("timer0 flag not set");

    property p_t0_hold;
        @(posedge clk_i) disable iff (rst_i)
            rd0[irq_flags_pkg::TIMER0_OVF_BIT] && !clr0[irq_flags_pkg::TIMER0_OVF_BIT]
            |=> rd0[irq_flags_pkg::TIMER0_OVF_BIT];
    endproperty
    a_t0_hold: assert property (p_t0_hold) else $error("timer0 flag dropped");

    property p_summary;
        @(posedge clk_i) disable iff (rst_i) rd0[irq_flags_pkg::PIN_SUMMARY_BIT] == (port_flags != 24'h000000);
    endproperty
    a_summary: assert property (p_summary) else $error("summary mismatch");

    property p_ext_set;
        @(posedge clk_i) disable iff (rst_i) events_i.ext_pin |=> rd0[irq_flags_pkg::EXT_PIN_BIT];
    endproperty
    a_ext_set: assert property (p_ext_set) else $error("ext flag not set");

    property p_set_wins;
        @(posedge clk_i) disable iff (rst_i) (|(set1 & clr1)) |=> (|(flags1_reg & $past(set1 & clr1)));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("set lost to clear");

    property p_rx;
        @(posedge clk_i) disable iff (rst_i) rd1[irq_flags_pkg::RX_PENDING_BIT] == events_i.rx_not_empty;
    endproperty
    a_rx: assert property (p_rx) else $error("rx flag mismatch");

    property p_tx;
        @(posedge clk_i) disable iff (rst_i) rd1[irq_flags_pkg::TX_EMPTY_BIT] == events_i.tx_empty;
    endproperty
    a_tx: assert property (p_tx) else $error("tx flag mismatch");

    property p_clear;
        @(posedge clk_i) disable iff (rst_i) (clr1 != 8'h00) && (set1 == 8'h00) |=> ((flags1_reg & $past(clr1)) == 8'h00);
    endproperty
    a_clear: assert property (p_clear) else $error("clear ignored");

    property p_reset;
        @(posedge clk_i) rst_i |=> (flags0_reg == 8'h00) && (flags1_reg == 8'h00);
    endproperty
    a_reset: assert property (p_reset) else $error("flags not reset");

    property p_ack_one;
        @(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack held");

    property p_ext_hold;
        @(posedge clk_i) disable iff (rst_i)
            rd0[irq_flags_pkg::EXT_PIN_BIT] && !clr0[irq_flags_pkg::EXT_PIN_BIT]
            |=> rd0[irq_flags_pkg::EXT_PIN_BIT];
    endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("ext flag dropped");

    property p_t0_clear;
        @(posedge clk_i) disable iff (rst_i)
            clr0[irq_flags_pkg::TIMER0_OVF_BIT] && !events_i.timer0_overflow
            |=> !rd0[irq_flags_pkg::TIMER0_OVF_BIT];
    endproperty
    a_t0_clear: assert property (p_t0_clear) else $error("timer0 flag not cleared");

    property p_ext_clear;
        @(posedge clk_i) disable iff (rst_i)
            clr0[irq_flags_pkg::EXT_PIN_BIT] && !events_i.ext_pin
            |=> !rd0[irq_flags_pkg::EXT_PIN_BIT];
    endproperty
    a_ext_clear: assert property (p_ext_clear) else $error("ext flag not cleared");

    property p_set1;
        @(posedge clk_i) disable iff (rst_i) (set1 != 8'h00) |=> ((flags1_reg & $past(set1)) == $past(set1));
    endproperty
    a_set1: assert property (p_set1) else $error("second register flag not set");

    property p_flags1_hold;
        @(posedge clk_i) disable iff (rst_i)
            (flags1_reg & ~clr1) != 8'h00
            |=> (flags1_reg & $past(flags1_reg & ~clr1)) == $past(flags1_reg & ~clr1);
    endproperty
    a_flags1_hold: assert property (p_flags1_hold) else $error("second register flag dropped");

    property p_ack_resp;
        @(posedge clk_i) disable iff (rst_i) req |=> ack_o;
    endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("request not acknowledged");

    property p_ack_cause;
        @(posedge clk_i) disable iff (rst_i) ack_o |-> $past(req);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");

    property p_unmapped;
        @(posedge clk_i) disable iff (rst_i)
            req && !(hit0 || hit1 || hit_st || hit_rise || hit_fall) |=> dat_o == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_mask_reset;
        @(posedge clk_i)
            rst_i |=> (rise_mask_reg == 24'h000000) && (fall_mask_reg == 24'h000000) && (port_flags == 24'h000000);
    endproperty
    a_mask_reset: assert property (p_mask_reset) else $error("pin state not reset");

    c_write: cover property (@(posedge clk_i) disable iff (rst_i) wr_stb && hit1);
    c_race:  cover property (@(posedge clk_i) disable iff (rst_i) |(set1 & clr1));
    c_pin:   cover property (@(posedge clk_i) disable iff (rst_i) $rose(summary));
    c_fall:  cover property (@(posedge clk_i) disable iff (rst_i) wr_stb && hit_fall);
    c_t0:    cover property (@(posedge clk_i) disable iff (rst_i)
                             events_i.timer0_overflow && clr0[irq_flags_pkg::TIMER0_OVF_BIT]);
endmodule
`default_nettype wire

/* testbench/periph_source.sv */
// Purpose: model of the peripherals that feed the request flag block
// Assumes: event pulses last one clk_i cycle; buffer states are levels
// Notes:   pin levels change only on clk_i edges
`timescale 1ns/1ps
`default_nettype none
module periph_source (
    input  wire logic                        clk_i,
    output var  irq_flags_pkg::irq_events_t  events_o,
    output var  logic [23:0]                 pins_o
);
    irq_flags_pkg::irq_events_t pulse_reg;
    logic                       rx_level;
    logic                       tx_level;

    initial begin
        pulse_reg = '0;
        rx_level  = 1'b0;
        tx_level  = 1'b0;
        pins_o    = 24'h000000;
    end

    // buffer levels override the pulse fields
    always_comb begin
        events_o              = pulse_reg;
        events_o.rx_not_empty = rx_level;
        events_o.tx_empty     = tx_level;
    end

    // one-cycle event pulse
    task automatic pulse(input irq_flags_pkg::irq_events_t ev);
        @(posedge clk_i);
        pulse_reg <= ev;
        @(posedge clk_i);
        pulse_reg <= '0;
    endtask
endmodule
`default_nettype wire

/* testbench/test_peripheral_irq_flags_0_1.sv */
// Purpose: self-checking bench for the request flag block
// Assumes: ack one cycle after a request is taken
// Notes:   pin tests cover rising, falling and masked-off edges
`timescale 1ns/1ps
`default_nettype none
module test_peripheral_irq_flags_0_1;
    logic                       clk_i = 1'b0;
    logic                       rst_i = 1'b1;
    logic                       cyc = 1'b0;
    logic                       stb = 1'b0;
    logic                       we = 1'b0;
    logic [3:0]                 sel = 4'h1;
    logic [31:0]                adr = 32'h0;
    logic [31:0]                dat = 32'h0;
    logic [31:0]                dat_o;
    logic                       ack_o;
    irq_flags_pkg::irq_events_t ev_w;
    logic [23:0]                pins_w;
    logic [7:0]                 flags0_o;
    logic [7:0]                 flags1_o;
    logic [31:0]                q;
    int                         n_errors = 0;
    int                         checks_done = 0;
    localparam int EV_K[8] = '{9, 8, 7, 6, 3, 2, 1, 0};
    localparam int EV_R[8] = '{0, 0, 1, 1, 1, 1, 1, 1};
    localparam int EV_B[8] = '{5, 0, 7, 6, 3, 2, 1, 0};

    always #25 clk_i = ~clk_i;

    periph_source src_u (.clk_i(clk_i), .events_o(ev_w), .pins_o(pins_w));

    peripheral_irq_flags dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .sel_i(sel),
        .adr_i(adr), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .events_i(ev_w), .pins_i(pins_w),
        .periph_request_flags_0_o(flags0_o), .periph_request_flags_1_o(flags1_o)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // classic cycle; ev pulses in the cycle the request is taken
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d,
                      input irq_flags_pkg::irq_events_t ev, output logic [31:0] r);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {27'h0, a};
        dat <= d;
        src_u.pulse_reg <= ev;
        @(posedge clk_i);
        src_u.pulse_reg <= '0;
        @(posedge clk_i iff ack_o === 1'b1);
        r = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_reset();
        src_u.pulse(irq_flags_pkg::irq_events_t'(10'h3ff));
        @(negedge clk_i);
        chk({16'h0, flags0_o, flags1_o}, 32'h21cf);
        do_reset();
        wb(1'b0, irq_flags_pkg::FLAGS0_OFFSET, 32'h0, '0, q);
        chk(q, 32'h0);
        wb(1'b0, irq_flags_pkg::FLAGS1_OFFSET, 32'h0, '0, q);
        chk(q, 32'h0);
    endtask

    task automatic test_events();
        logic [4:0] a;
        for (int i = 0; i < 8; i++) begin
            a = (EV_R[i] == 1) ? irq_flags_pkg::FLAGS1_OFFSET : irq_flags_pkg::FLAGS0_OFFSET;
            src_u.pulse(irq_flags_pkg::irq_events_t'(10'h1 << EV_K[i]));
            wb(1'b1, a, 32'hff, '0, q);
            wb(1'b0, a, 32'h0, '0, q);
            chk(q, 32'h1 << EV_B[i]);
            chk({24'h0, (EV_R[i] == 1) ? flags1_o : flags0_o}, 32'h1 << EV_B[i]);
            wb(1'b1, a, 32'h0, irq_flags_pkg::irq_events_t'(10'h1 << EV_K[i]), q);
            wb(1'b0, a, 32'h0, '0, q);
            chk(q, 32'h1 << EV_B[i]);
            wb(1'b1, a, 32'h0, '0, q);
            wb(1'b0, a, 32'h0, '0, q);
            chk(q, 32'h0);
        end
        wb(1'b1, irq_flags_pkg::FLAGS0_OFFSET, 32'hff, '0, q);
        wb(1'b0, irq_flags_pkg::FLAGS0_OFFSET, 32'h0, '0, q);
        chk(q, 32'h0);
    endtask

    task automatic test_levels();
        @(posedge clk_i);
        src_u.rx_level <= 1'b1;
        wb(1'b0, irq_flags_pkg::FLAGS1_OFFSET, 32'h0, '0, q);
        chk(q, 32'h20);
        src_u.tx_level <= 1'b1;
        wb(1'b1, irq_flags_pkg::FLAGS1_OFFSET, 32'h0, '0, q);
        wb(1'b0, irq_flags_pkg::FLAGS1_OFFSET, 32'h0, '0, q);
        chk(q, 32'h30);
        src_u.rx_level <= 1'b0;
        wb(1'b0, irq_flags_pkg::FLAGS1_OFFSET, 32'h0, '0, q);
        chk(q, 32'h10);
        src_u.tx_level <= 1'b0;
        wb(1'b0, irq_flags_pkg::FLAGS1_OFFSET, 32'h0, '0, q);
        chk(q, 32'h0);
    endtask

    task automatic test_pins();
        wb(1'b1, irq_flags_pkg::RISE_MASK_OFFSET, 32'h1, '0, q);
        src_u.pins_o <= 24'h000002;
        repeat (10) @(posedge clk_i);
        @(negedge clk_i);
        chk({24'h0, flags0_o}, 32'h0);
        @(posedge clk_i);
        src_u.pins_o <= 24'h000003;
        for (int n = 0; n < 12 && flags0_o !== 8'h10; n++) @(posedge clk_i);
        wb(1'b0, irq_flags_pkg::STATUS_OFFSET, 32'h0, '0, q);
        chk(q, 32'h1);
        wb(1'b1, irq_flags_pkg::FLAGS0_OFFSET, 32'h0, '0, q);
        wb(1'b0, irq_flags_pkg::FLAGS0_OFFSET, 32'h0, '0, q);
        chk(q, 32'h10);
        wb(1'b1, irq_flags_pkg::STATUS_OFFSET, 32'h0, '0, q);
        wb(1'b0, irq_flags_pkg::FLAGS0_OFFSET, 32'h0, '0, q);
        chk(q, 32'h0);
        wb(1'b1, irq_flags_pkg::FALL_MASK_OFFSET, 32'h2, '0, q);
        src_u.pins_o <= 24'h000001;
        repeat (8) @(posedge clk_i);
        src_u.pins_o <= 24'h000000;
        repeat (8) @(posedge clk_i);
        wb(1'b0, irq_flags_pkg::STATUS_OFFSET, 32'h0, '0, q);
        chk(q, 32'h2);
        wb(1'b0, irq_flags_pkg::FALL_MASK_OFFSET, 32'h0, '0, q);
        chk(q, 32'h2);
        wb(1'b1, 5'h14, 32'hffffffff, '0, q);
        wb(1'b0, 5'h14, 32'h0, '0, q);
        chk(q, 32'h0);
    endtask

    initial begin
        do_reset();
        test_reset();
        test_events();
        test_levels();
        test_pins();
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
